/* File: hw/dtu_pkg.sv */
// Package for the dual 16-bit multifunction timer: register map, fields, enums and carriers.
package dtu_pkg;

    // ****************************************************************
    // Register byte offsets on the AXI4-Lite slave
    // ****************************************************************
    localparam logic [7:0] off_ctrl = 8'h00;
    localparam logic [7:0] off_clksel = 8'h04;
    localparam logic [7:0] off_prescale = 8'h08;
    localparam logic [7:0] off_reg_a = 8'h0c;
    localparam logic [7:0] off_reg_b = 8'h10;
    localparam logic [7:0] off_cnt1 = 8'h14;
    localparam logic [7:0] off_cnt2 = 8'h18;
    localparam logic [7:0] off_irq_en = 8'h1c;
    localparam logic [7:0] off_pending = 8'h20;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    // Control register
    localparam int ctrl_mode_lsb = 0;
    localparam int ctrl_toggle_en = 2;
    localparam int ctrl_pin_a_init = 3;
    localparam int ctrl_b_edge_rise = 4;
    localparam int ctrl_b_level_high = 5;
    localparam int ctrl_a_edge_rise = 6;
    localparam int ctrl_preset_a = 7;
    localparam int ctrl_preset_b = 8;
    localparam int ctrl_width = 9;
    // Clock select register
    localparam int clksel1_lsb = 0;
    localparam int clksel2_lsb = 4;
    // Enable and pending bits
    localparam int bit_a = 0;
    localparam int bit_b = 1;
    localparam int bit_c = 2;
    localparam int bit_d = 3;

    // ****************************************************************
    // Reset values and constants
    // ****************************************************************
    localparam logic [15:0] cnt_all_ones = 16'hffff;
    localparam logic [15:0] cnt_zero = 16'h0000;
    localparam logic [4:0] prescale_reset = 5'h00;
    localparam logic [1:0] axi_okay = 2'h0;
    localparam logic [1:0] axi_slverr = 2'h2;

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        dtu_mode_pwm = 2'h0,
        dtu_mode_dual_capture = 2'h1,
        dtu_mode_dual_timer = 2'h2,
        dtu_mode_capture_timer = 2'h3
    } dtu_mode_type;

    typedef enum logic [2:0] {
        dtu_clk_none = 3'h0,
        dtu_clk_prescaled = 3'h1,
        dtu_clk_event = 3'h2,
        dtu_clk_accumulate = 3'h3,
        dtu_clk_slow = 3'h4
    } dtu_clksel_type;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic preset_b;
        logic preset_a;
        logic a_edge_rise;
        logic b_level_high;
        logic b_edge_rise;
        logic pin_a_init;
        logic toggle_en;
        dtu_mode_type mode;
    } dtu_ctrl_type;

    typedef struct packed {
        logic second_underflow;
        logic c;
        logic b;
        logic a;
    } dtu_flags_type;

endpackage : dtu_pkg

/* File: hw/dtu_timer.sv */
// Dual 16-bit down counter timer with prescaler, clock selectors and an AXI4-Lite register slave.
`timescale 1ns/10ps

module dtu_timer #(
    parameter int cnt_width = 16,
    parameter int presc_width = 5
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer pins
    input wire logic io_pin_a_i,
    output logic io_pin_a_o,
    output logic io_pin_a_oe,
    input wire logic io_pin_b_i,
    input wire logic slow_clk_i,
    // Interrupts
    output logic irq_counter1,
    output logic irq_counter2
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (cnt_width != 16 || presc_width != 5) begin : g_bad_param
        $error("dtu_timer supports only a 16-bit counter and 5-bit prescaler");
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    dtu_pkg::dtu_ctrl_type ctrl_q;
    dtu_pkg::dtu_clksel_type clksel1_q, clksel2_q;
    logic [presc_width-1:0] prescale_divisor_reg_q, presc_cnt_q;
    logic [cnt_width-1:0] reload_capture_reg_a_q, reload_capture_reg_b_q;
    logic [cnt_width-1:0] first_down_counter_q, second_down_counter_q;
    dtu_pkg::dtu_flags_type irq_en_q, pend_q;
    logic [1:0] pin_a_sync_q, pin_b_sync_q, slow_sync_q;
    logic pin_a_last_q, pin_b_last_q, slow_last_q;
    logic use_b_next_q, pin_a_level_q;
    dtu_pkg::dtu_mode_type mode_last_q;
    logic clk1_was_none_q;

    // ****************************************************************
    // Bus write/read decode
    // ****************************************************************
    logic [7:0] aw_addr_q;
    logic aw_have_q, w_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic [31:0] wmask;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{w_strb_q[i]}};
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [31:0] m);
        merge = (old & ~m) | (val & m);
    endfunction : merge

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a <= dtu_pkg::off_pending) && (a[1:0] == 2'h0);
    endfunction : addr_known

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dtu_pkg::axi_okay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_known(aw_addr_q) ? dtu_pkg::axi_okay : dtu_pkg::axi_slverr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic [31:0] rd_value;
    always_comb begin
        rd_value = 32'h0000_0000;
        case (s_axi_araddr)
            dtu_pkg::off_ctrl: rd_value = 32'(ctrl_q);
            dtu_pkg::off_clksel: rd_value = {24'h00_0000, 1'b0, clksel2_q, 1'b0, clksel1_q};
            dtu_pkg::off_prescale: rd_value = 32'(prescale_divisor_reg_q);
            dtu_pkg::off_reg_a: rd_value = 32'(reload_capture_reg_a_q);
            dtu_pkg::off_reg_b: rd_value = 32'(reload_capture_reg_b_q);
            dtu_pkg::off_cnt1: rd_value = 32'(first_down_counter_q);
            dtu_pkg::off_cnt2: rd_value = 32'(second_down_counter_q);
            dtu_pkg::off_irq_en: rd_value = 32'(irq_en_q);
            dtu_pkg::off_pending: rd_value = 32'(pend_q);
            default: rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= dtu_pkg::axi_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= addr_known(s_axi_araddr) ? dtu_pkg::axi_okay : dtu_pkg::axi_slverr;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    logic wr_ctrl, wr_clksel, wr_presc, wr_a, wr_b, wr_c1, wr_c2, wr_en, wr_pend;
    assign wr_ctrl = do_write && aw_addr_q == dtu_pkg::off_ctrl;
    assign wr_clksel = do_write && aw_addr_q == dtu_pkg::off_clksel;
    assign wr_presc = do_write && aw_addr_q == dtu_pkg::off_prescale;
    assign wr_a = do_write && aw_addr_q == dtu_pkg::off_reg_a;
    assign wr_b = do_write && aw_addr_q == dtu_pkg::off_reg_b;
    assign wr_c1 = do_write && aw_addr_q == dtu_pkg::off_cnt1;
    assign wr_c2 = do_write && aw_addr_q == dtu_pkg::off_cnt2;
    assign wr_en = do_write && aw_addr_q == dtu_pkg::off_irq_en;
    assign wr_pend = do_write && aw_addr_q == dtu_pkg::off_pending;

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [31:0] ctrl_w, clksel_w;
    assign ctrl_w = merge(32'(ctrl_q), w_data_q, wmask);
    assign clksel_w = merge({24'h00_0000, 1'b0, clksel2_q, 1'b0, clksel1_q}, w_data_q, wmask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= '0;
            clksel1_q <= dtu_pkg::dtu_clk_none;
            clksel2_q <= dtu_pkg::dtu_clk_none;
            prescale_divisor_reg_q <= dtu_pkg::prescale_reset;
            irq_en_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= dtu_pkg::dtu_ctrl_type'(ctrl_w[dtu_pkg::ctrl_width-1:0]);
            end
            if (wr_clksel) begin
                clksel1_q <= dtu_pkg::dtu_clksel_type'(clksel_w[dtu_pkg::clksel1_lsb +: 3]);
                clksel2_q <= dtu_pkg::dtu_clksel_type'(clksel_w[dtu_pkg::clksel2_lsb +: 3]);
            end
            if (wr_presc) begin
                prescale_divisor_reg_q <= presc_width'(merge(32'(prescale_divisor_reg_q), w_data_q, wmask));
            end
            if (wr_en) begin
                irq_en_q <= dtu_pkg::dtu_flags_type'(w_data_q[3:0] & wmask[3:0]
                    | 4'(irq_en_q) & ~wmask[3:0]);
            end
        end
    end

    // ****************************************************************
    // Synchronisers and edge detection
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_a_sync_q <= 2'h0;
            pin_b_sync_q <= 2'h0;
            slow_sync_q <= 2'h0;
            pin_a_last_q <= 1'b0;
            pin_b_last_q <= 1'b0;
            slow_last_q <= 1'b0;
        end else begin
            pin_a_sync_q <= {pin_a_sync_q[0], io_pin_a_i};
            pin_b_sync_q <= {pin_b_sync_q[0], io_pin_b_i};
            slow_sync_q <= {slow_sync_q[0], slow_clk_i};
            pin_a_last_q <= pin_a_sync_q[1];
            pin_b_last_q <= pin_b_sync_q[1];
            slow_last_q <= slow_sync_q[1];
        end
    end

    logic pin_a_s, pin_b_s, a_event, b_event, slow_tick;
    assign pin_a_s = pin_a_sync_q[1];
    assign pin_b_s = pin_b_sync_q[1];
    // Edges seen one per sampled change, so pin-B counting tops out at half aclk
    assign a_event = ctrl_q.a_edge_rise ? (pin_a_s && !pin_a_last_q) : (!pin_a_s && pin_a_last_q);
    assign b_event = ctrl_q.b_edge_rise ? (pin_b_s && !pin_b_last_q) : (!pin_b_s && pin_b_last_q);
    // Counts only on aclk edges, so a stopped system clock pauses slow counting
    assign slow_tick = slow_sync_q[1] && !slow_last_q;

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    logic presc_tick;
    assign presc_tick = (presc_cnt_q == '0);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_cnt_q <= dtu_pkg::prescale_reset;
        end else if (presc_tick) begin
            presc_cnt_q <= prescale_divisor_reg_q;
        end else begin
            presc_cnt_q <= presc_cnt_q - 1'b1;
        end
    end

    // ****************************************************************
    // Clock selection
    // ****************************************************************
    function automatic logic pick_clk(input dtu_pkg::dtu_clksel_type sel, input logic p_tick,
                                      input logic b_ev, input logic b_lvl_ok, input logic s_tick);
        case (sel)
            dtu_pkg::dtu_clk_prescaled: pick_clk = p_tick;
            dtu_pkg::dtu_clk_event: pick_clk = b_ev;
            dtu_pkg::dtu_clk_accumulate: pick_clk = p_tick && b_lvl_ok;
            dtu_pkg::dtu_clk_slow: pick_clk = s_tick;
            default: pick_clk = 1'b0;
        endcase
    endfunction : pick_clk

    logic b_level_ok, cap_mode, c1_pin_b_src, tick1, tick2;
    assign b_level_ok = (pin_b_s == ctrl_q.b_level_high);
    assign cap_mode = (ctrl_q.mode == dtu_pkg::dtu_mode_dual_capture);
    assign c1_pin_b_src = (clksel1_q == dtu_pkg::dtu_clk_event) || (clksel1_q == dtu_pkg::dtu_clk_accumulate);
    assign tick1 = !(cap_mode && c1_pin_b_src)
        && pick_clk(clksel1_q, presc_tick, b_event, b_level_ok, slow_tick);
    assign tick2 = pick_clk(clksel2_q, presc_tick, b_event, b_level_ok, slow_tick);

    // ****************************************************************
    // Counters, reload and capture
    // ****************************************************************
    logic uf1, uf2, mode_pwm, mode_dual, mode_mix, cap_a, cap_b1, cap_b2, reload_a, reload_b;
    assign uf1 = tick1 && first_down_counter_q == dtu_pkg::cnt_zero;
    assign uf2 = tick2 && second_down_counter_q == dtu_pkg::cnt_zero;
    assign mode_pwm = ctrl_q.mode == dtu_pkg::dtu_mode_pwm;
    assign mode_dual = ctrl_q.mode == dtu_pkg::dtu_mode_dual_timer;
    assign mode_mix = ctrl_q.mode == dtu_pkg::dtu_mode_capture_timer;
    assign cap_a = cap_mode && a_event;
    assign cap_b1 = cap_mode && b_event;
    assign cap_b2 = mode_mix && b_event;

    // Restart state that forces the next mode 1 reload to come from A
    logic restart_a, use_b_now;
    assign restart_a = (mode_last_q != ctrl_q.mode) || (clk1_was_none_q && clksel1_q != dtu_pkg::dtu_clk_none);
    // A restart also steers a reload in the same cycle to A
    assign use_b_now = use_b_next_q && !restart_a;
    assign reload_a = uf1 && (!mode_pwm || !use_b_now);
    assign reload_b = uf1 && mode_pwm && use_b_now;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_last_q <= dtu_pkg::dtu_mode_pwm;
            clk1_was_none_q <= 1'b1;
            use_b_next_q <= 1'b0;
        end else begin
            mode_last_q <= ctrl_q.mode;
            clk1_was_none_q <= (clksel1_q == dtu_pkg::dtu_clk_none);
            if (uf1 && mode_pwm) begin
                use_b_next_q <= !use_b_now;
            end else if (restart_a) begin
                use_b_next_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_down_counter_q <= dtu_pkg::cnt_zero;
        end else if (wr_c1) begin
            first_down_counter_q <= cnt_width'(merge(32'(first_down_counter_q), w_data_q, wmask));
        end else if ((cap_a && ctrl_q.preset_a) || (cap_b1 && ctrl_q.preset_b)) begin
            first_down_counter_q <= dtu_pkg::cnt_all_ones;
        end else if (uf1 && mode_pwm) begin
            first_down_counter_q <= use_b_now ? reload_capture_reg_b_q : reload_capture_reg_a_q;
        end else if (uf1 && (mode_dual || mode_mix)) begin
            first_down_counter_q <= reload_capture_reg_a_q;
        end else if (tick1) begin
            first_down_counter_q <= first_down_counter_q - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            second_down_counter_q <= dtu_pkg::cnt_zero;
        end else if (wr_c2) begin
            second_down_counter_q <= cnt_width'(merge(32'(second_down_counter_q), w_data_q, wmask));
        end else if (cap_b2 && ctrl_q.preset_b) begin
            second_down_counter_q <= dtu_pkg::cnt_all_ones;
        end else if (uf2 && mode_dual) begin
            second_down_counter_q <= reload_capture_reg_b_q;
        end else if (tick2) begin
            second_down_counter_q <= second_down_counter_q - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_capture_reg_a_q <= dtu_pkg::cnt_zero;
            reload_capture_reg_b_q <= dtu_pkg::cnt_zero;
        end else begin
            if (cap_a) begin
                reload_capture_reg_a_q <= first_down_counter_q;
            end else if (wr_a) begin
                reload_capture_reg_a_q <= cnt_width'(merge(32'(reload_capture_reg_a_q), w_data_q, wmask));
            end
            if (cap_b1) begin
                reload_capture_reg_b_q <= first_down_counter_q;
            end else if (cap_b2) begin
                reload_capture_reg_b_q <= second_down_counter_q;
            end else if (wr_b) begin
                reload_capture_reg_b_q <= cnt_width'(merge(32'(reload_capture_reg_b_q), w_data_q, wmask));
            end
        end
    end

    // ****************************************************************
    // Pin A waveform
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_a_level_q <= 1'b0;
        end else if (wr_ctrl) begin
            pin_a_level_q <= ctrl_w[dtu_pkg::ctrl_pin_a_init];
        end else if (uf1 && ctrl_q.toggle_en && !cap_mode) begin
            pin_a_level_q <= !pin_a_level_q;
        end
    end
    assign io_pin_a_o = pin_a_level_q;
    assign io_pin_a_oe = ctrl_q.toggle_en && !cap_mode;

    // ****************************************************************
    // Pending flags and interrupts
    // ****************************************************************
    dtu_pkg::dtu_flags_type set_f, clr_f;
    always_comb begin
        set_f.a = reload_a && (mode_pwm || mode_dual || mode_mix) || cap_a;
        set_f.b = reload_b || cap_b1 || cap_b2;
        set_f.c = uf1 && cap_mode;
        set_f.second_underflow = uf2;
        clr_f = wr_pend ? dtu_pkg::dtu_flags_type'(w_data_q[3:0] & wmask[3:0]) : '0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= '0;
        end else begin
            // Write one clears; a same-cycle hardware set wins
            pend_q <= (pend_q & ~clr_f) | set_f;
        end
    end

    always_comb begin
        irq_counter1 = (pend_q.a && irq_en_q.a) || (pend_q.c && irq_en_q.c)
            || (pend_q.b && irq_en_q.b && !mode_mix);
        irq_counter2 = (pend_q.second_underflow && irq_en_q.second_underflow)
            || (pend_q.b && irq_en_q.b && mode_mix);
    end

endmodule : dtu_timer

/* File: dv/dtu_checker.sv */
// Handshake and pin enable checker of the dual timer.
`timescale 1ns/10ps
module dtu_checker (
    // Clock, reset and bus handshakes
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    // Pin enable
    input wire logic io_pin_a_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bh; $fell(s_axi_bvalid) |-> $past(s_axi_bready); endproperty
    a_bh: assert property (p_bh) else $error("bvalid dropped early");
    property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bd: assert property (p_bd) else $error("bvalid held after bready");
    property p_rd; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("rvalid held after rready");
    property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_busy: assert property (p_busy) else $error("write taken while response pending");
    property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar: assert property (p_ar) else $error("read taken while data pending");
    property p_rv; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read data late");
    property p_bw; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##[1:2] s_axi_bvalid; endproperty
    a_bw: assert property (p_bw) else $error("write response late");
    property p_oe; $changed(io_pin_a_oe) |-> $rose(s_axi_bvalid); endproperty
    a_oe: assert property (p_oe) else $error("pin enable moved without a write");
endmodule : dtu_checker
bind dtu_timer dtu_checker chk_u (.*);

/* File: dv/tb_top.sv */
// Self-checking bench of the dual timer over its register bus.
`timescale 1ns/10ps
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, ta, tw, tb;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, hold;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, io_pin_a_o, io_pin_a_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic io_pin_a_i = 1'b0, io_pin_b_i = 1'b0, slow_clk_i = 1'b0, irq_counter1, irq_counter2;
    int num_errors = 0, n_checks = 0;
    dtu_timer dut_u (.*);
    always #10 aclk = ~aclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Handshake values are sampled mid-cycle, which equals what the next rising edge sees
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rdr(input logic [7:0] a, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_arready;
            tb = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tb);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        chk({30'h0, rs}, {30'h0, er});
    endtask : rdr
    // Pin pulses stay four cycles high and four low, inside the pin-B event rate limit
    task automatic pls(input logic on_b, input int n);
        repeat (n) begin
            if (on_b) io_pin_b_i <= 1'b1;
            else io_pin_a_i <= 1'b1;
            repeat (4) @(posedge aclk);
            if (on_b) io_pin_b_i <= 1'b0;
            else io_pin_a_i <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask : pls
    task automatic conclude();
        if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(dtu_pkg::off_prescale, dtu_pkg::axi_okay);
        chk(rd, 32'h0);
        wr(dtu_pkg::off_prescale, 32'h1f);
        chk({30'h0, rs}, {30'h0, dtu_pkg::axi_okay});
        rdr(dtu_pkg::off_prescale, dtu_pkg::axi_okay);
        chk(rd, 32'h1f);
        rdr(8'h24, dtu_pkg::axi_slverr);
        chk(rd, 32'h0);
        wr(8'h24, 32'h1);
        chk({30'h0, rs}, {30'h0, dtu_pkg::axi_slverr});
        // Alternating reload with toggle on pin A, counter 2 underflow enabled
        wr(dtu_pkg::off_irq_en, 32'h9);
        wr(dtu_pkg::off_ctrl, 32'h4);
        wr(dtu_pkg::off_reg_a, 32'h28);
        wr(dtu_pkg::off_reg_b, 32'h28);
        wr(dtu_pkg::off_prescale, 32'h0);
        // Let the prescaler drain the count left from the old divisor
        repeat (32) @(posedge aclk);
        wr(dtu_pkg::off_clksel, 32'h11);
        rdr(dtu_pkg::off_pending, dtu_pkg::axi_okay);
        chk(rd, 32'h9);
        chk({31'h0, io_pin_a_o}, 32'h1);
        chk({30'h0, irq_counter2, irq_counter1}, 32'h3);
        chk({31'h0, io_pin_a_oe}, 32'h1);
        repeat (45) @(posedge aclk);
        rdr(dtu_pkg::off_pending, dtu_pkg::axi_okay);
        chk(rd, 32'hb);
        chk({31'h0, io_pin_a_o}, 32'h0);
        wr(dtu_pkg::off_pending, 32'hb);
        chk({30'h0, irq_counter2, irq_counter1}, 32'h0);
        wr(dtu_pkg::off_clksel, 32'h0);
        rdr(dtu_pkg::off_cnt1, dtu_pkg::axi_okay);
        hold = rd;
        repeat (5) @(posedge aclk);
        rdr(dtu_pkg::off_cnt1, dtu_pkg::axi_okay);
        chk(rd, hold);
        // Mode 3: counter 2 clocked by rising pin-B edges reloads from B on underflow
        wr(dtu_pkg::off_ctrl, 32'h12);
        chk({31'h0, io_pin_a_oe}, 32'h0);
        wr(dtu_pkg::off_reg_b, 32'h7);
        wr(dtu_pkg::off_cnt2, 32'h2);
        wr(dtu_pkg::off_clksel, 32'h20);
        pls(1'b1, 3);
        rdr(dtu_pkg::off_cnt2, dtu_pkg::axi_okay);
        chk(rd, 32'h7);
        rdr(dtu_pkg::off_pending, dtu_pkg::axi_okay);
        chk(rd, 32'h8);
        chk({30'h0, irq_counter2, irq_counter1}, 32'h2);
        // Mode 2: pin-A rising capture with preset, pin-B falling capture, counter 1 halted
        wr(dtu_pkg::off_pending, 32'hf);
        wr(dtu_pkg::off_ctrl, 32'hc1);
        wr(dtu_pkg::off_cnt1, 32'h1234);
        wr(dtu_pkg::off_clksel, 32'h2);
        pls(1'b0, 1);
        pls(1'b1, 1);
        rdr(dtu_pkg::off_reg_a, dtu_pkg::axi_okay);
        chk(rd, 32'h1234);
        rdr(dtu_pkg::off_cnt1, dtu_pkg::axi_okay);
        chk(rd, 32'hffff);
        rdr(dtu_pkg::off_reg_b, dtu_pkg::axi_okay);
        chk(rd, 32'hffff);
        rdr(dtu_pkg::off_pending, dtu_pkg::axi_okay);
        chk(rd, 32'h3);
        chk({30'h0, irq_counter2, irq_counter1}, 32'h1);
        conclude();
    end
    initial begin
        repeat (2000) @(posedge aclk);
        num_errors++;
        conclude();
    end
endmodule : tb_top
